// ---- i2c_bus_engine_model.sv ----
// stand-in for the bus sequencing engine and the remote parties behind it
// assumes the block samples each event pulse on the rising edge of i_clk
module i2c_bus_engine_model (
  input  wire logic        i_clk,
  output logic      [12:0] o_ev,
  output logic      [7:0]  o_byte
);
  initial begin
    o_ev   = '0;
    o_byte = 8'h00;
  end

  // one-cycle pulse; the byte is not held afterwards, the shifter moves on
  task automatic fire(input logic [12:0] m, input logic [7:0] b);
    @(posedge i_clk);
    o_ev   <= m;
    o_byte <= b;
    @(posedge i_clk);
    o_ev   <= '0;
    o_byte <= ~b;
  endtask
endmodule

// ---- i2c_status_clock_divider.sv ----
// status flags, interrupt mask, internal address and scl waveform generator of a two-wire controller
// assumes a bus sequencing engine on the same clock that reports bus events as one-cycle pulses
//
// Function
// RULE1 - internal address register supplies zero to three bytes chosen by size field
// RULE2 - master scl low lasts low divider times two to prescale plus four
// RULE3 - master scl high lasts high divider times two to prescale plus four
// RULE4 - master done flag low during frame, high after empty and stop sent
// RULE5 - slave done flag clears on start, sets on stop or foreign readdress
// RULE6 - rx full sets on byte load, clears when holding register read
// RULE7 - master tx empty clears on write, sets on shift, nack, enable
// RULE8 - slave tx empty low from write until byte sent and acknowledged
// RULE9 - software must not write tx holding while tx empty and nack set
// RULE10 - slave read flag shows direction of current slave access
// RULE11 - slave addressed sets on address match, clears on nack or stop
// RULE12 - general call flag sets on detection, clears on status read
// RULE13 - overrun sets on reload while full, status read clears it if done
// RULE14 - master nack flag sets with done, clears on status read
// RULE15 - slave read nack sets on master nack; slave write acks every byte
// RULE16 - arbitration lost sets with done, clears on status read
// RULE17 - slave stretches clock and flags it when buffer not ready
// RULE18 - access end flag sets when slave addressed clears, cleared by read
// RULE19 - enable register write sets mask bits written one
// RULE20 - disable register write clears mask bits written one
// RULE21 - mask register reads enabled sources, zero after reset
// RULE22 - size field codes zero to three internal address bytes
// RULE23 - interrupt output high while any enabled status flag set
`include "i2c_status_consts.svh"

module i2c_status_clock_divider (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [31:0]           i_addr,
  input  wire i2c_status_pkg::word_t i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output i2c_status_pkg::word_t      o_rdata,
  input  wire logic                  i_master_mode,
  input  wire logic                  i_frame_start,
  input  wire logic                  i_stop_sent,
  input  wire logic                  i_byte_to_shifter,
  input  wire logic                  i_rx_load,
  input  wire i2c_status_pkg::byte_t i_rx_byte,
  input  wire logic                  i_master_nack,
  input  wire logic                  i_arb_lost,
  input  wire logic                  i_start_det,
  input  wire logic                  i_stop_det,
  input  wire logic                  i_readdr_mismatch,
  input  wire logic                  i_addr_match,
  input  wire logic                  i_addr_read,
  input  wire logic                  i_general_call,
  input  wire logic                  i_slave_tx_acked,
  input  wire logic                  i_slave_nack,
  input  wire logic                  i_next_byte_due,
  output logic                       o_scl_out,
  output logic                       o_scl_stretch,
  output logic                       o_slave_rx_ack,
  output logic [23:0]                o_internal_addr_bytes,
  output logic [1:0]                 o_internal_addr_size,
  output i2c_status_pkg::byte_t      o_tx_data,
  output logic                       o_master_enable_cmd,
  output logic                       o_irq
);
  import i2c_status_pkg::*;

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire hit_ctl   = (i_addr == `OFS_CONTROL);
  wire hit_asz   = (i_addr == `OFS_ADDR_SIZE);
  wire hit_internal_addr_bytes  = (i_addr == `OFS_INTERNAL_ADDR);
  wire hit_cwg   = (i_addr == `OFS_CLOCK_WAVE);
  wire hit_stat  = (i_addr == `OFS_STATUS);
  wire hit_ien   = (i_addr == `OFS_IRQ_ENABLE);
  wire hit_idis  = (i_addr == `OFS_IRQ_DISABLE);
  wire hit_imask = (i_addr == `OFS_IRQ_MASK);
  wire hit_rhr   = (i_addr == `OFS_RX_HOLDING);
  wire hit_thr   = (i_addr == `OFS_TX_HOLDING);

  wire wr_thr    = i_wr & hit_thr;
  wire rd_stat   = i_rd & hit_stat;
  wire rd_rhr    = i_rd & hit_rhr;
  wire master_enable_cmd_cmd  = i_wr & hit_ctl & i_wdata[`CTL_MASTER_ENABLE];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [23:0] internal_addr_bytes_reg;
  logic [1:0]  asz_reg;
  logic [7:0]  low_div_reg;
  logic [7:0]  high_div_reg;
  logic [2:0]  prescale_reg;
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  byte_t       thr_reg;
  byte_t       rhr_reg;

  // RULE19 RULE20 mask set and clear
  assign mask_next = (mask_reg | (i_wr & hit_ien ? i_wdata : 32'h00000000))
                     & ~(i_wr & hit_idis ? i_wdata : 32'h00000000) & `IRQ_VALID_BITS;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      internal_addr_bytes_reg     <= `INTERNAL_ADDR_RESET;
      asz_reg      <= 2'h0;
      low_div_reg  <= 8'h00;
      high_div_reg <= 8'h00;
      prescale_reg <= 3'h0;
      mask_reg     <= `IRQ_MASK_RESET;
      thr_reg      <= 8'h00;
    end else begin
      // RULE1 RULE22 address bytes and size
      if (i_wr & hit_internal_addr_bytes) internal_addr_bytes_reg <= i_wdata[23:0];
      if (i_wr & hit_asz) asz_reg <= i_wdata[`ASZ_LSB +: 2];
      if (i_wr & hit_cwg) begin
        low_div_reg  <= i_wdata[`CWG_LOW_LSB +: 8];
        high_div_reg <= i_wdata[`CWG_HIGH_LSB +: 8];
        prescale_reg <= i_wdata[`CWG_PRESCALE_LSB +: 3];
      end
      mask_reg <= mask_next;
      if (wr_thr) thr_reg <= i_wdata[7:0];
    end
  end

  // RULE1 unused high bytes read back as zero on the address outputs
  wire [23:0] internal_addr_bytes_used = (asz_reg == 2'h0) ? 24'h000000 :
                          (asz_reg == 2'h1) ? {16'h0000, internal_addr_bytes_reg[7:0]} :
                          (asz_reg == 2'h2) ? {8'h00, internal_addr_bytes_reg[15:0]} : internal_addr_bytes_reg;

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic transfer_done_reg, rx_holding_full_reg, tx_holding_empty_reg, slave_read_dir_reg, slave_addressed_reg, general_call_seen_reg;
  logic rx_overrun_reg, nack_reg, arb_reg, clock_stretch_flag_reg, slave_access_end_reg;
  wire  slave_mode = ~i_master_mode;

  // RULE4 RULE5 done flag: set wins over clear
  wire transfer_done_set = i_master_mode ? (i_stop_sent | i_master_nack | i_arb_lost)
                                  : (i_stop_det | i_readdr_mismatch);
  wire transfer_done_clr = i_master_mode ? i_frame_start : i_start_det;
  wire transfer_done_next = transfer_done_set | (transfer_done_reg & ~transfer_done_clr);

  // RULE6 rx full
  wire rx_holding_full_next = i_rx_load | (rx_holding_full_reg & ~rd_rhr);

  // RULE7 RULE8 tx empty, RULE9 relies on software not writing while nack stands
  wire tx_holding_empty_set = i_master_mode ? (i_byte_to_shifter | i_master_nack | master_enable_cmd_cmd)
                                 : i_slave_tx_acked;
  wire tx_holding_empty_next = tx_holding_empty_set | (tx_holding_empty_reg & ~wr_thr);

  // RULE11 slave addressed
  wire slave_addressed_next = (slave_mode & i_addr_match) |
                    (slave_addressed_reg & ~(i_slave_nack | i_stop_det));
  // RULE10 direction caught at address match
  wire slave_read_dir_next = (slave_mode & i_addr_match) ? i_addr_read : slave_read_dir_reg;
  // RULE12 general call
  wire general_call_seen_next = (slave_mode & i_general_call) | (general_call_seen_reg & ~rd_stat);
  // RULE13 overrun: read clears only with done set
  wire rx_overrun_next = (i_master_mode & i_rx_load & rx_holding_full_reg) |
                   (rx_overrun_reg & ~(rd_stat & transfer_done_reg));
  // RULE14 RULE15 nack in master and slave read
  wire nack_set  = (i_master_mode & i_master_nack) |
                   (slave_mode & slave_addressed_reg & slave_read_dir_reg & i_slave_nack);
  wire nack_next = nack_set | (nack_reg & ~rd_stat);
  // RULE16 arbitration lost
  wire arb_next = (i_master_mode & i_arb_lost) | (arb_reg & ~rd_stat);
  // RULE17 stretch while the holding buffer is not ready for the next byte
  wire clock_stretch_flag_next = slave_mode & slave_addressed_reg & i_next_byte_due &
                    (slave_read_dir_reg ? tx_holding_empty_reg : rx_holding_full_reg);
  // RULE18 access end on falling slave addressed
  wire slave_access_end_next = (slave_addressed_reg & ~slave_addressed_next) | (slave_access_end_reg & ~rd_stat);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      transfer_done_reg <= 1'b1;
      rx_holding_full_reg  <= 1'b0;
      tx_holding_empty_reg  <= 1'b0;
      slave_read_dir_reg <= 1'b1;
      slave_addressed_reg  <= 1'b0;
      general_call_seen_reg   <= 1'b0;
      rx_overrun_reg   <= 1'b0;
      nack_reg   <= 1'b0;
      arb_reg    <= 1'b0;
      clock_stretch_flag_reg  <= 1'b0;
      slave_access_end_reg <= 1'b0;
      rhr_reg    <= 8'h00;
    end else begin
      transfer_done_reg <= transfer_done_next;
      rx_holding_full_reg  <= rx_holding_full_next;
      tx_holding_empty_reg  <= tx_holding_empty_next;
      slave_read_dir_reg <= slave_read_dir_next;
      slave_addressed_reg  <= slave_addressed_next;
      general_call_seen_reg   <= general_call_seen_next;
      rx_overrun_reg   <= rx_overrun_next;
      nack_reg   <= nack_next;
      arb_reg    <= arb_next;
      clock_stretch_flag_reg  <= clock_stretch_flag_next;
      slave_access_end_reg <= slave_access_end_next;
      if (i_rx_load) rhr_reg <= i_rx_byte;
    end
  end

  wire [31:0] status_word = `STATUS_RSVD_ONES |
    ({31'h00000000, transfer_done_reg} << `ST_TRANSFER_DONE) |
    ({31'h00000000, rx_holding_full_reg}  << `ST_RX_FULL)       |
    ({31'h00000000, tx_holding_empty_reg}  << `ST_TX_EMPTY)      |
    ({31'h00000000, slave_read_dir_reg} << `ST_SLAVE_READ)    |
    ({31'h00000000, slave_addressed_reg}  << `ST_SLAVE_ADDR)    |
    ({31'h00000000, general_call_seen_reg}   << `ST_GENERAL_CALL)  |
    ({31'h00000000, rx_overrun_reg}   << `ST_RX_OVERRUN)    |
    ({31'h00000000, nack_reg}   << `ST_NACK)          |
    ({31'h00000000, arb_reg}    << `ST_ARB_LOST)      |
    ({31'h00000000, clock_stretch_flag_reg}  << `ST_CLK_STRETCH)   |
    ({31'h00000000, slave_access_end_reg} << `ST_ACCESS_END);

  // ----------------------------------------------------------------
  // read mux, one cycle latency, unmapped reads return zero
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    hit_asz   ? {22'h000000, asz_reg, 8'h00} :
    hit_internal_addr_bytes  ? {8'h00, internal_addr_bytes_reg} :
    hit_cwg   ? {13'h0000, prescale_reg, high_div_reg, low_div_reg} :
    hit_stat  ? status_word :
    hit_imask ? mask_reg :
    hit_rhr   ? {24'h000000, rhr_reg} : 32'h00000000;

  // ----------------------------------------------------------------
  // scl waveform generator
  // ----------------------------------------------------------------
  // the divider is shifted before the add so a prescale of 7 still fits in 16 bits
  function automatic logic [15:0] phase_len(input logic [7:0] div, input logic [2:0] pre);
    phase_len = ({8'h00, div} << pre) + `SCL_PHASE_EXTRA;
  endfunction

  scl_phase_t  phase_reg;
  logic [15:0] cnt_reg;
  wire         scl_run  = i_master_mode & ~transfer_done_reg;
  wire [15:0]  low_len  = phase_len(low_div_reg, prescale_reg);
  wire [15:0]  high_len = phase_len(high_div_reg, prescale_reg);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !scl_run) begin
      phase_reg <= SCL_HIGH;
      cnt_reg   <= 16'h0000;
    end else if (cnt_reg == 16'h0000) begin
      // RULE2 RULE3 each phase lasts its full length counted down to zero
      unique case (phase_reg)
        SCL_HIGH: begin
          phase_reg <= SCL_LOW;
          cnt_reg   <= low_len - 16'h0001;
        end
        SCL_LOW: begin
          phase_reg <= SCL_HIGH;
          cnt_reg   <= high_len - 16'h0001;
        end
      endcase
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata               <= 32'h00000000;
      o_scl_stretch         <= 1'b0;
      o_slave_rx_ack        <= 1'b0;
      o_internal_addr_bytes <= `INTERNAL_ADDR_RESET;
      o_internal_addr_size  <= 2'h0;
      o_tx_data             <= 8'h00;
      o_master_enable_cmd   <= 1'b0;
      o_irq                 <= 1'b0;
    end else begin
      o_rdata               <= i_rd ? rd_mux : 32'h00000000;
      // RULE17 stretch tracks the wait flag
      o_scl_stretch         <= clock_stretch_flag_next;
      // RULE15 every byte of a slave write is acknowledged
      o_slave_rx_ack        <= slave_addressed_next & ~slave_read_dir_next;
      o_internal_addr_bytes <= internal_addr_bytes_used;
      o_internal_addr_size  <= asz_reg;
      o_tx_data             <= thr_reg;
      o_master_enable_cmd   <= master_enable_cmd_cmd;
      // RULE23 interrupt from enabled flags
      o_irq                 <= |(status_word & mask_reg);
    end
  end

  // scl output mirrors the phase flip-flop
  assign o_scl_out = (phase_reg == SCL_HIGH);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_rx_full_set: assert property (i_rx_load |=> rx_holding_full_reg) // RULE6
    else $error("rx full not set after load");
  a_rx_full_clr: assert property (rd_rhr && !i_rx_load |=> !rx_holding_full_reg) // RULE6
    else $error("rx full not cleared by read");
  a_tx_write_clr: assert property (wr_thr && !tx_holding_empty_set |=> !tx_holding_empty_reg) // RULE7
    else $error("tx empty not cleared by write");
  a_tx_enable_set: assert property (i_master_mode && master_enable_cmd_cmd |=> tx_holding_empty_reg) // RULE7
    else $error("tx empty not set on master enable");
  a_slave_tx_ack: assert property (slave_mode && i_slave_tx_acked |=> tx_holding_empty_reg) // RULE8
    else $error("slave tx empty not set after ack");
  a_done_master_clr: assert property (i_master_mode && i_frame_start && !transfer_done_set |=> !transfer_done_reg) // RULE4
    else $error("done not cleared at frame start");
  a_done_slave_set: assert property (slave_mode && i_stop_det |=> transfer_done_reg) // RULE5
    else $error("done not set after slave stop");
  a_slave_addressed_hold: assert property (slave_addressed_reg && !i_slave_nack && !i_stop_det |=> slave_addressed_reg) // RULE11
    else $error("slave addressed dropped early");
  a_slave_read_dir_dir: assert property (slave_mode && i_addr_match |=> slave_read_dir_reg == $past(i_addr_read)) // RULE10
    else $error("slave read direction wrong");
  a_general_call_seen_read: assert property (general_call_seen_reg && rd_stat && !i_general_call |=> !general_call_seen_reg) // RULE12
    else $error("general call not cleared by status read");
  a_rx_overrun_keep: assert property (rx_overrun_reg && rd_stat && !transfer_done_reg |=> rx_overrun_reg) // RULE13
    else $error("overrun cleared without done");
  a_nack_done: assert property (i_master_mode && i_master_nack |=> nack_reg && transfer_done_reg && tx_holding_empty_reg) // RULE14
    else $error("master nack flags not set together");
  a_slave_nack: assert property (slave_mode && slave_addressed_reg && slave_read_dir_reg && i_slave_nack |=> nack_reg) // RULE15
    else $error("slave read nack not flagged");
  a_arb_done: assert property (i_master_mode && i_arb_lost |=> arb_reg && transfer_done_reg) // RULE16
    else $error("arbitration lost flags not set together");
  a_stretch_flag: assert property (clock_stretch_flag_reg == o_scl_stretch) // RULE17
    else $error("stretch output disagrees with flag");
  a_access_end: assert property ($fell(slave_addressed_reg) |-> slave_access_end_reg) // RULE18
    else $error("access end not set when access ends");
  a_mask_enable: assert property (i_wr && hit_ien && !(i_wr && hit_idis) |=> (mask_reg & $past(i_wdata) & `IRQ_VALID_BITS) == ($past(i_wdata) & `IRQ_VALID_BITS)) // RULE19
    else $error("enable write did not set mask bits");
  a_mask_disable: assert property (i_wr && hit_idis |=> (mask_reg & $past(i_wdata)) == 32'h00000000) // RULE20
    else $error("disable write did not clear mask bits");
  a_mask_read: assert property (i_rd && hit_imask |=> o_rdata == $past(mask_reg)) // RULE21
    else $error("mask read data wrong");
  a_irq_level: assert property (##1 o_irq == |($past(status_word) & $past(mask_reg))) // RULE23
    else $error("interrupt output wrong");
  a_scl_low_len: assert property ($rose(phase_reg == SCL_LOW) && scl_run |-> cnt_reg == low_len - 16'h0001) // RULE2
    else $error("scl low length wrong");
  a_scl_high_len: assert property ($fell(phase_reg == SCL_LOW) && scl_run |-> cnt_reg == high_len - 16'h0001) // RULE3
    else $error("scl high length wrong");
  a_internal_addr_bytes_size: assert property (asz_reg == 2'h1 |=> o_internal_addr_bytes[23:8] == 16'h0000) // RULE1
    else $error("unused internal address bytes not zero");

  c_slave_access: cover property (slave_addressed_reg ##[1:50] slave_access_end_reg);
  c_overrun: cover property (i_master_mode && i_rx_load && rx_holding_full_reg);
  c_scl_cycle: cover property ($rose(phase_reg == SCL_LOW) ##[1:100] $fell(phase_reg == SCL_LOW));
  c_stretch: cover property (o_scl_stretch);
endmodule

// ---- i2c_status_clock_divider_bench.sv ----
// self-checking bench for the status flags, interrupt mask, internal address and scl generator
// assumes the event model pulses one event vector; bit order is the dut_u port list below
`include "i2c_status_consts.svh"
module i2c_status_clock_divider_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_status_pkg::*;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic        mm = 1'b1, ard = 1'b0, due = 1'b0;
  logic        scl, str, ack, mcmd, irq;
  logic [31:0] i_addr = '0;
  logic [23:0] ia;
  logic [1:0]  isz;
  logic [12:0] ev;
  byte_t       rx_b, txd;
  word_t       i_wdata = '0, rdata, v, e, d, msk;
  int          bad_count = 0, n_checks = 0, lo, hi, pr, n, lo_m, hi_m;

  i2c_status_clock_divider dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_master_mode(mm), .i_frame_start(ev[0]), .i_stop_sent(ev[1]),
    .i_byte_to_shifter(ev[2]), .i_rx_load(ev[3]), .i_rx_byte(rx_b), .i_master_nack(ev[4]), .i_arb_lost(ev[5]),
    .i_start_det(ev[6]), .i_stop_det(ev[7]), .i_readdr_mismatch(ev[8]), .i_addr_match(ev[9]), .i_addr_read(ard),
    .i_general_call(ev[10]), .i_slave_tx_acked(ev[11]), .i_slave_nack(ev[12]), .i_next_byte_due(due),
    .o_scl_out(scl), .o_scl_stretch(str), .o_slave_rx_ack(ack), .o_internal_addr_bytes(ia),
    .o_internal_addr_size(isz), .o_tx_data(txd), .o_master_enable_cmd(mcmd), .o_irq(irq));
  i2c_bus_engine_model src_u (.i_clk(i_clk), .o_ev(ev), .o_byte(rx_b));

  always #4 i_clk = ~i_clk;

  function automatic word_t bt(input int i);
    return word_t'(1) << i;
  endfunction
  function automatic word_t iaddr_exp(input word_t a, input int s);
    return (s == 0) ? '0 : a & ((word_t'(1) << (8 * s)) - 1);
  endfunction
  task automatic chk_word(input word_t got, input word_t exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input word_t a, input word_t dv);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= dv;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input word_t a, output word_t dv);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    dv = rdata;
  endtask
  task automatic st(input word_t m, input word_t x);
    rd(`OFS_STATUS, v);
    chk_word(v & m, x);
  endtask
  task automatic span(input logic l, output int c);
    c = 0;
    while (scl === l && c < 4000) begin
      @(posedge i_clk);
      #1;
      c++;
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic final_report();
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(30522));
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    st(32'hFFFFFFFF, `STATUS_RESET);
    rd(`OFS_IRQ_MASK, v);
    chk_word(v, `IRQ_MASK_RESET);
    rd(32'hF8010018, v);
    chk_word(v, 32'h0);
    for (int s = 0; s < 4; s++) begin
      e = $urandom;
      wr(`OFS_ADDR_SIZE, word_t'(s) << `ASZ_LSB);
      wr(`OFS_INTERNAL_ADDR, e);
      settle();
      chk_word({30'h0, isz}, word_t'(s));
      chk_word({8'h0, ia}, iaddr_exp(e, s));
      rd(`OFS_INTERNAL_ADDR, v);
      chk_word(v, e & 32'h00FFFFFF);
    end
    msk = '0;
    repeat (4) begin
      e = $urandom;
      d = $urandom;
      wr(`OFS_IRQ_ENABLE, e);
      msk = (msk | e) & `IRQ_VALID_BITS;
      rd(`OFS_IRQ_MASK, v);
      chk_word(v, msk);
      wr(`OFS_IRQ_DISABLE, d);
      msk = msk & ~d;
      rd(`OFS_IRQ_MASK, v);
      chk_word(v, msk);
    end
    wr(`OFS_IRQ_DISABLE, 32'hFFFFFFFF);
    wr(`OFS_IRQ_ENABLE, bt(`ST_TRANSFER_DONE));
    settle();
    chk_bit(irq, 1'b1);
    wr(`OFS_IRQ_DISABLE, bt(`ST_TRANSFER_DONE));
    settle();
    chk_bit(irq, 1'b0);
    wr(`OFS_CONTROL, bt(`CTL_MASTER_ENABLE));
    #1 chk_bit(mcmd, 1'b1);
    st(bt(`ST_TX_EMPTY), bt(`ST_TX_EMPTY));
    e = $urandom & 32'hFF;
    wr(`OFS_TX_HOLDING, e);
    st(bt(`ST_TX_EMPTY), 32'h0);
    chk_word({24'h0, txd}, e);
    src_u.fire(13'h0004, 8'h00);
    st(bt(`ST_TX_EMPTY), bt(`ST_TX_EMPTY));
    lo = $urandom_range(7);
    hi = $urandom_range(7);
    pr = $urandom_range(2);
    wr(`OFS_CLOCK_WAVE, (word_t'(hi) << `CWG_HIGH_LSB) | (word_t'(pr) << `CWG_PRESCALE_LSB) | word_t'(lo));
    src_u.fire(13'h0001, 8'h00);
    st(bt(`ST_TRANSFER_DONE), 32'h0);
    span(1'b0, n);
    span(1'b1, n);
    span(1'b0, lo_m);
    span(1'b1, hi_m);
    chk_word(word_t'(lo_m), word_t'((lo << pr) + 4));
    chk_word(word_t'(hi_m), word_t'((hi << pr) + 4));
    src_u.fire(13'h0002, 8'h00);
    st(bt(`ST_TRANSFER_DONE), bt(`ST_TRANSFER_DONE));
    settle();
    chk_bit(scl, 1'b1);
    e = $urandom & 32'hFF;
    src_u.fire(13'h0008, e[7:0]);
    st(bt(`ST_RX_FULL), bt(`ST_RX_FULL));
    rd(`OFS_RX_HOLDING, v);
    chk_word(v, e);
    st(bt(`ST_RX_FULL), 32'h0);
    src_u.fire(13'h0001, 8'h00);
    src_u.fire(13'h0008, 8'h3C);
    src_u.fire(13'h0008, 8'hC3);
    st(bt(`ST_RX_OVERRUN), bt(`ST_RX_OVERRUN));
    st(bt(`ST_RX_OVERRUN), bt(`ST_RX_OVERRUN));
    src_u.fire(13'h0002, 8'h00);
    st(bt(`ST_RX_OVERRUN), bt(`ST_RX_OVERRUN));
    st(bt(`ST_RX_OVERRUN), 32'h0);
    // no tx holding write follows a nack while tx empty is up
    for (int k = 0; k < 2; k++) begin
      msk = bt(`ST_TRANSFER_DONE) | bt(`ST_TX_EMPTY) | bt(k ? `ST_ARB_LOST : `ST_NACK);
      src_u.fire(13'h0001, 8'h00);
      src_u.fire(k ? 13'h0020 : 13'h0010, 8'h00);
      st(msk, msk);
      st(bt(k ? `ST_ARB_LOST : `ST_NACK), 32'h0);
    end
    @(posedge i_clk);
    mm  <= 1'b0;
    ard <= 1'b1;
    src_u.fire(13'h0040, 8'h00);
    st(bt(`ST_TRANSFER_DONE), 32'h0);
    src_u.fire(13'h0200, 8'h00);
    msk = bt(`ST_SLAVE_READ) | bt(`ST_SLAVE_ADDR);
    st(msk, msk);
    src_u.fire(13'h0400, 8'h00);
    st(bt(`ST_GENERAL_CALL), bt(`ST_GENERAL_CALL));
    st(bt(`ST_GENERAL_CALL), 32'h0);
    wr(`OFS_TX_HOLDING, $urandom & 32'hFF);
    st(bt(`ST_TX_EMPTY), 32'h0);
    src_u.fire(13'h0800, 8'h00);
    st(bt(`ST_TX_EMPTY), bt(`ST_TX_EMPTY));
    src_u.fire(13'h1000, 8'h00);
    msk = bt(`ST_NACK) | bt(`ST_SLAVE_ADDR) | bt(`ST_ACCESS_END);
    st(msk, bt(`ST_NACK) | bt(`ST_ACCESS_END));
    st(bt(`ST_ACCESS_END), 32'h0);
    @(posedge i_clk);
    ard <= 1'b0;
    src_u.fire(13'h0200, 8'h00);
    st(bt(`ST_SLAVE_READ) | bt(`ST_SLAVE_ADDR), bt(`ST_SLAVE_ADDR));
    chk_bit(ack, 1'b1);
    src_u.fire(13'h0008, 8'h96);
    due <= 1'b1;
    settle();
    chk_bit(str, 1'b1);
    st(bt(`ST_CLK_STRETCH), bt(`ST_CLK_STRETCH));
    rd(`OFS_RX_HOLDING, v);
    settle();
    chk_bit(str, 1'b0);
    due <= 1'b0;
    src_u.fire(13'h0080, 8'h00);
    msk = bt(`ST_TRANSFER_DONE) | bt(`ST_SLAVE_ADDR) | bt(`ST_ACCESS_END);
    st(msk, bt(`ST_TRANSFER_DONE) | bt(`ST_ACCESS_END));
    src_u.fire(13'h0040, 8'h00);
    src_u.fire(13'h0100, 8'h00);
    st(bt(`ST_TRANSFER_DONE), bt(`ST_TRANSFER_DONE));
    final_report();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    final_report();
  end
endmodule

// ---- i2c_status_consts.svh ----
// offsets, field positions, reset values and timing counts of the status / clock divider block
// assumes a byte-addressed register port with 32-bit words
`ifndef I2C_STATUS_CONSTS_SVH
`define I2C_STATUS_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define OFS_CONTROL        32'hF8010000
`define OFS_ADDR_SIZE      32'hF8010004
`define OFS_INTERNAL_ADDR  32'hF801000C
`define OFS_CLOCK_WAVE     32'hF8010010
`define OFS_STATUS         32'hF8010020
`define OFS_IRQ_ENABLE     32'hF8010024
`define OFS_IRQ_DISABLE    32'hF8010028
`define OFS_IRQ_MASK       32'hF801002C
`define OFS_RX_HOLDING     32'hF8010030
`define OFS_TX_HOLDING     32'hF8010034

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTL_MASTER_ENABLE  2
`define ASZ_LSB            8
`define CWG_LOW_LSB        0
`define CWG_HIGH_LSB       8
`define CWG_PRESCALE_LSB   16
`define ST_TRANSFER_DONE   0
`define ST_RX_FULL         1
`define ST_TX_EMPTY        2
`define ST_SLAVE_READ      3
`define ST_SLAVE_ADDR      4
`define ST_GENERAL_CALL    5
`define ST_RX_OVERRUN      6
`define ST_NACK            8
`define ST_ARB_LOST        9
`define ST_CLK_STRETCH     10
`define ST_ACCESS_END      11

// ----------------------------------------------------------------
// reset values and fixed patterns
// ----------------------------------------------------------------
`define STATUS_RESET       32'h0000F009
`define STATUS_RSVD_ONES   32'h0000F000
`define IRQ_VALID_BITS     32'h00000F77
`define IRQ_MASK_RESET     32'h00000000
`define INTERNAL_ADDR_RESET 24'h000000
`define CLOCK_WAVE_RESET   19'h00000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCL_PHASE_EXTRA    16'h0004
`endif

// ---- i2c_status_pkg.sv ----
// types shared by the status / clock divider block
// assumes i2c_status_consts.svh for all numbers
package i2c_status_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  byte_t;
  typedef enum logic {SCL_HIGH, SCL_LOW} scl_phase_t;
endpackage
